//--- rtl/eeprom_access_controller.sv
// Operation
// - Reset lets running programming finish
// - Offsets 0x00-0x1F accept bit set/clear
// - Data-space address is I/O plus 0x20
// - Bit operations touch only the addressed bit
// - High address register always reads zero
// - Low address byte selects one of 256
// - Data register feeds writes, receives reads
// - Mode field selects operation and duration
// - Mode writes ignored while programming
// - Reset clears mode unless programming
// - Ready interrupt requested while idle, enabled
// - Write arm self-clears after four cycles
// - Program enable without arm does nothing
// - Program enable clears when time elapses
// - Accepted program start stalls CPU two cycles
// - Read strobe fetches byte, stalls four
// - Programming blocks reads and address changes
// - Control bits 7 and 6 read zero
`timescale 1ns/1ps
module eeprom_access_controller
	import nv_access_pkg::*;
#(
	parameter int ATOMIC_CYCLES = ATOMIC_PROG_CYCLES,
	parameter int SPLIT_CYCLES = SPLIT_PROG_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input io_req_t ioReq,
	input wire logic globalIrqEnable,
	output logic [7:0] ioRdata,
	output logic cpuStall,
	output logic readyIrq
);
	localparam logic [TIMER_W-1:0] ATOMIC_LIMIT = TIMER_W'(ATOMIC_CYCLES);
	localparam logic [TIMER_W-1:0] SPLIT_LIMIT = TIMER_W'(SPLIT_CYCLES);

	logic [6:0] rawAddr;
	logic [5:0] ioAddr;
	logic inRange;
	logic bitOp;
	logic [7:0] curVal;
	logic [7:0] wrMask;
	logic [7:0] wrVal;
	logic ctrlWr;
	logic dataWr;
	logic addrWr;

	prog_mode_t modeQ;
	prog_mode_t modeEff;
	logic modeWr;
	logic irqEnQ;
	logic armQ;
	logic [2:0] armCntQ;
	logic armSet;
	logic readQ;
	logic rdStart;
	logic peWr;
	logic progStart;
	logic progBusy;
	logic timerDone;
	logic [TIMER_W-1:0] progLimit;
	logic [7:0] dataQ;
	logic [7:0] addrQ;
	logic [7:0] opAddrQ;
	logic [7:0] opDataQ;
	prog_mode_t opModeQ;
	logic [7:0] memRdata;
	logic [7:0] memWdata;
	logic [2:0] stallCntQ;
	logic [7:0] rdataQ;
	logic [7:0] ctrlView;

	assign ctrlView = {2'b00, modeQ, irqEnQ, armQ, progBusy, readQ};

	// Address decode for both I/O and data-space views
	always_comb begin
		rawAddr = ioReq.addr;
		inRange = (ioReq.addr <= IO_LAST);
		if (ioReq.dataSpace) begin
			rawAddr = 7'(ioReq.addr - DATA_SPACE_OFS);
			inRange = (ioReq.addr >= DATA_SPACE_OFS) && (ioReq.addr <= DATA_SPACE_LAST);
		end
		ioAddr = rawAddr[5:0];
	end

	always_comb begin
		unique case (ioAddr)
			CTRL_OFS: curVal = ctrlView;
			DATA_OFS: curVal = dataQ;
			ADDRL_OFS: curVal = addrQ;
			ADDRH_OFS: curVal = ZERO_BYTE;
			default: curVal = ZERO_BYTE;
		endcase
	end

	// Bit operations only reach the low half of I/O space
	assign bitOp = (ioReq.bitSet || ioReq.bitClear) && !ioReq.dataSpace
		&& (ioReq.addr <= IO_BITOP_LAST);

	always_comb begin
		wrMask = ZERO_BYTE;
		wrVal = ZERO_BYTE;
		if (bitOp) begin
			wrMask[ioReq.bitSel] = 1'b1;
			wrVal = curVal;
			wrVal[ioReq.bitSel] = ioReq.bitSet;
		end else if (ioReq.wr && inRange) begin
			wrMask = ERASED_BYTE;
			wrVal = ioReq.wdata;
		end
	end

	assign ctrlWr = (wrMask != ZERO_BYTE) && (ioAddr == CTRL_OFS);
	assign dataWr = (wrMask != ZERO_BYTE) && (ioAddr == DATA_OFS);
	assign addrWr = (wrMask != ZERO_BYTE) && (ioAddr == ADDRL_OFS);

	// Mode field
	assign modeWr = ctrlWr && (wrMask[BIT_MODE_HI] || wrMask[BIT_MODE_LO]) && !progBusy;
	assign modeEff = modeWr ? prog_mode_t'(wrVal[BIT_MODE_HI:BIT_MODE_LO]) : modeQ;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			if (!progBusy) begin
				modeQ <= MODE_RST;
			end
		end else if (modeWr) begin
			modeQ <= prog_mode_t'(wrVal[BIT_MODE_HI:BIT_MODE_LO]);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irqEnQ <= 1'b0;
		end else if (ctrlWr && wrMask[BIT_IRQEN]) begin
			irqEnQ <= wrVal[BIT_IRQEN];
		end
	end

	// Write arm window; a second arm write inside it does not extend it
	assign armSet = ctrlWr && wrMask[BIT_ARM] && wrVal[BIT_ARM] && !armQ;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			armQ <= 1'b0;
			armCntQ <= 3'h0;
		end else if (armSet) begin
			armQ <= 1'b1;
			armCntQ <= ARM_WINDOW_CYCLES;
		end else if (armQ) begin
			armCntQ <= armCntQ - 3'h1;
			if (armCntQ == 3'h1) begin
				armQ <= 1'b0;
			end
		end
	end

	// Programming start; the reserved mode starts nothing
	assign peWr = ctrlWr && wrMask[BIT_PROG] && wrVal[BIT_PROG];
	assign progStart = peWr && armQ && !progBusy && !sys_rst && (modeEff != MODE_RSVD);
	assign progLimit = (modeEff == MODE_ATOMIC) ? ATOMIC_LIMIT : SPLIT_LIMIT;

	prog_timer timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(progStart),
		.limit(progLimit),
		.running(progBusy),
		.done(timerDone)
	);

	// Operands are frozen at start so a reset cannot disturb them
	always_ff @(posedge clock) begin
		if (progStart) begin
			opAddrQ <= addrQ;
			opDataQ <= dataQ;
			opModeQ <= modeEff;
		end else if (sys_rst && !progBusy) begin
			opAddrQ <= ADDR_RST;
			opDataQ <= DATA_RST;
			opModeQ <= MODE_RST;
		end
	end

	always_comb begin
		unique case (opModeQ)
			MODE_ATOMIC: memWdata = opDataQ;
			MODE_ERASE: memWdata = ERASED_BYTE;
			MODE_WRITE: memWdata = memRdata & opDataQ;
			MODE_RSVD: memWdata = memRdata;
		endcase
	end

	// Read strobe
	assign rdStart = ctrlWr && wrMask[BIT_READ] && wrVal[BIT_READ] && !progBusy
		&& !readQ && !sys_rst && !progStart;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			readQ <= 1'b0;
		end else begin
			readQ <= rdStart;
		end
	end

	nv_array array (
		.clock(clock),
		.rdEn(rdStart || progStart),
		.wrEn(timerDone),
		.addr(timerDone ? opAddrQ : addrQ),
		.wdata(memWdata),
		.rdata(memRdata)
	);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dataQ <= DATA_RST;
		end else if (readQ) begin
			dataQ <= memRdata;
		end else if (dataWr) begin
			dataQ <= wrVal;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			if (!progBusy) begin
				addrQ <= ADDR_RST;
			end
		end else if (addrWr && !progBusy) begin
			addrQ <= wrVal;
		end
	end

	// CPU stall
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stallCntQ <= 3'h0;
		end else if (progStart) begin
			stallCntQ <= STALL_PROG_CYCLES;
		end else if (rdStart) begin
			stallCntQ <= STALL_READ_CYCLES;
		end else if (stallCntQ != 3'h0) begin
			stallCntQ <= stallCntQ - 3'h1;
		end
	end

	assign cpuStall = (stallCntQ != 3'h0);

	// Level request, not an event: it stays up for as long as the array is idle and both enables are set
	assign readyIrq = irqEnQ && globalIrqEnable && !progBusy;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdataQ <= ZERO_BYTE;
		end else if (ioReq.rd && inRange) begin
			rdataQ <= curVal;
		end else begin
			rdataQ <= ZERO_BYTE;
		end
	end

	assign ioRdata = rdataQ;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_arm_window;
		armSet |=> armQ [*4] ##1 !armQ;
	endproperty
	a_arm_window: assert property (p_arm_window) else $error("Arm window wrong");

	property p_pe_needs_arm;
		peWr && !armQ && !progBusy |=> !progBusy;
	endproperty
	a_pe_needs_arm: assert property (p_pe_needs_arm) else $error("Start without arm");

	property p_prog_stall;
		progStart |=> cpuStall [*2] ##1 !cpuStall;
	endproperty
	a_prog_stall: assert property (p_prog_stall) else $error("Program stall wrong");

	property p_read_stall;
		rdStart |=> cpuStall [*4] ##1 !cpuStall;
	endproperty
	a_read_stall: assert property (p_read_stall) else $error("Read stall wrong");

	property p_read_clears;
		rdStart |=> readQ ##1 (!readQ && dataQ == $past(memRdata));
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("Read strobe stuck");

	property p_read_blocked;
		progBusy && ctrlWr && wrMask[BIT_READ] && wrVal[BIT_READ] |=> !readQ;
	endproperty
	a_read_blocked: assert property (p_read_blocked) else $error("Read while busy");

	property p_addr_frozen;
		progBusy && $past(progBusy) |-> $stable(addrQ);
	endproperty
	a_addr_frozen: assert property (p_addr_frozen) else $error("Address moved");

	property p_mode_frozen;
		progBusy && $past(progBusy) |-> $stable(modeQ);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen) else $error("Mode moved");

	property p_done_clears;
		timerDone |=> !progBusy && !ctrlView[BIT_PROG];
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("Enable not cleared");

	property p_irq_level;
		(irqEnQ && globalIrqEnable && !progBusy) [*2] |-> readyIrq && $past(readyIrq);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Ready request missing");

	property p_mode_reset;
		disable iff (1'b0) sys_rst && !progBusy |=> modeQ == MODE_RST;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("Mode not reset");

	property p_reset_keeps_prog;
		disable iff (1'b0) sys_rst && progBusy |=> $stable(modeQ) && $stable(addrQ);
	endproperty
	a_reset_keeps_prog: assert property (p_reset_keeps_prog) else $error("Reset hit op");

	property p_rsvd_zero;
		$past(ioReq.rd && inRange && (ioAddr == CTRL_OFS || ioAddr == ADDRH_OFS))
			|-> rdataQ[7:6] == 2'b00 && ($past(ioAddr) != ADDRH_OFS || rdataQ == ZERO_BYTE);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits set");

	property p_bit_only;
		bitOp && ctrlWr && ioReq.bitSel == 3'(BIT_IRQEN) |=> $stable(modeQ);
	endproperty
	a_bit_only: assert property (p_bit_only) else $error("Bit op spilled");

endmodule : eeprom_access_controller

//--- rtl/nv_access_pkg.sv
package nv_access_pkg;

	// I/O space layout
	localparam logic [6:0] IO_LAST = 7'h3F;
	localparam logic [6:0] IO_BITOP_LAST = 7'h1F;
	localparam logic [6:0] DATA_SPACE_OFS = 7'h20;
	localparam logic [6:0] DATA_SPACE_LAST = 7'h5F;

	// Register offsets in I/O space
	localparam logic [5:0] CTRL_OFS = 6'h1C;
	localparam logic [5:0] DATA_OFS = 6'h1D;
	localparam logic [5:0] ADDRL_OFS = 6'h1E;
	localparam logic [5:0] ADDRH_OFS = 6'h1F;

	// Control register fields
	localparam int BIT_READ = 0;
	localparam int BIT_PROG = 1;
	localparam int BIT_ARM = 2;
	localparam int BIT_IRQEN = 3;
	localparam int BIT_MODE_LO = 4;
	localparam int BIT_MODE_HI = 5;

	// Reset values and byte constants
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	typedef enum logic [1:0] {
		MODE_ATOMIC = 2'h0,
		MODE_ERASE = 2'h1,
		MODE_WRITE = 2'h2,
		MODE_RSVD = 2'h3
	} prog_mode_t;

	localparam prog_mode_t MODE_RST = MODE_ATOMIC;

	// Timing
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int ATOMIC_TIME_NS = 3400000;
	localparam int SPLIT_TIME_NS = 1800000;
	localparam int ATOMIC_PROG_CYCLES = (ATOMIC_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SPLIT_PROG_CYCLES = (SPLIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int TIMER_W = 19;
	localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
	localparam logic [2:0] STALL_PROG_CYCLES = 3'h2;
	localparam logic [2:0] STALL_READ_CYCLES = 3'h4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic bitSet;
		logic bitClear;
		logic dataSpace;
		logic [6:0] addr;
		logic [2:0] bitSel;
		logic [7:0] wdata;
	} io_req_t;

endpackage : nv_access_pkg

//--- rtl/nv_array.sv
`timescale 1ns/1ps
module nv_array (
	input wire logic clock,
	input wire logic rdEn,
	input wire logic wrEn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] cells [256];

	always_ff @(posedge clock) begin
		if (wrEn) begin
			cells[addr] <= wdata;
		end
	end

	// No reset: an interrupted write-only cycle still needs the old byte
	always_ff @(posedge clock) begin
		if (rdEn) begin
			rdata <= cells[addr];
		end
	end

endmodule : nv_array

//--- rtl/prog_timer.sv
`timescale 1ns/1ps
module prog_timer
	import nv_access_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [TIMER_W-1:0] limit,
	output logic running,
	output logic done
);
	// Power-up value so a running operation can survive reset
	logic runQ = 1'b0;
	logic [TIMER_W-1:0] cntQ;

	always_ff @(posedge clock) begin
		if (start) begin
			runQ <= 1'b1;
			cntQ <= limit;
		end else if (runQ) begin
			cntQ <= cntQ - 1'b1;
			if (cntQ == 1) begin
				runQ <= 1'b0;
			end
		end else if (sys_rst) begin
			cntQ <= '0;
		end
	end

	assign running = runQ;
	assign done = runQ && (cntQ == 1);

	property p_timer_len;
		@(posedge clock) $fell(runQ) |-> $past(cntQ) == 1;
	endproperty
	a_timer_len: assert property (p_timer_len) else $error("Timer ended early");

	property p_timer_reset;
		@(posedge clock) runQ && !done |=> runQ;
	endproperty
	a_timer_reset: assert property (p_timer_reset) else $error("Timer aborted");

endmodule : prog_timer

//--- test/cpu_model.sv
`timescale 1ns/1ps
module cpu_model
	import nv_access_pkg::*;
(
	input wire logic clock,
	input wire logic cpuStall,
	output io_req_t ioReq,
	output int hangs
);
	initial ioReq = '0;
	// Any wait that runs out of its bound is counted here for the verdict
	initial hangs = 0;
	// One request per call; k: 0 write, 1 read, 2 bit set, 3 bit clear
	task automatic access(input logic [1:0] k, input logic ds, input logic [6:0] a,
		input logic [2:0] b, input logic [7:0] d, output int st);
		int n;
		n = 0;
		st = 0;
		while (cpuStall !== 1'b0 && n < 50) begin
			@(negedge clock);
			n++;
		end
		if (n >= 50) hangs++;
		@(negedge clock);
		ioReq = {k == 2'd0, k == 2'd1, k == 2'd2, k == 2'd3, ds, a, b, d};
		@(negedge clock);
		// Strobes drop; address, bit and data lines show inverted values so stale data cannot pass
		ioReq = {5'b00000, ~a, ~b, ~d};
		// Stall counted per cycle so the bench can check its length
		while (cpuStall === 1'b1 && st < 20) begin
			@(negedge clock);
			st++;
		end
		if (cpuStall === 1'b1) hangs++;
	endtask : access
endmodule : cpu_model

//--- test/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	import nv_access_pkg::*;
	localparam int AC = 20;
	localparam int SC = 10;
	logic clock = 0;
	logic sys_rst = 1;
	logic globalIrqEnable = 0;
	io_req_t ioReq;
	logic [7:0] ioRdata;
	logic cpuStall;
	logic readyIrq;
	int num_errors = 0;
	int tests_run = 0;
	int hangs;
	int st;
	logic [7:0] expQ[$];
	logic rdSeen = 0;
	logic [7:0] a0, d0, ex;
	initial forever #5 clock = ~clock;
	eeprom_access_controller #(.ATOMIC_CYCLES(AC), .SPLIT_CYCLES(SC)) dut (.clock(clock),
		.sys_rst(sys_rst), .ioReq(ioReq), .globalIrqEnable(globalIrqEnable),
		.ioRdata(ioRdata), .cpuStall(cpuStall), .readyIrq(readyIrq));
	cpu_model cpu (.clock(clock), .cpuStall(cpuStall), .ioReq(ioReq), .hangs(hangs));
	always @(posedge clock) rdSeen <= ioReq.rd;
	always @(negedge clock) begin
		if (rdSeen) begin
			if (expQ.size() == 0) begin
				`CHK("queue", 1'b1, 1'b0)
			end else begin
				`CHK("rdata", expQ.pop_front(), ioRdata)
			end
		end
	end
	task summarize();
		if (hangs != 0) begin
			num_errors += hangs;
			$display("BAD hangs exp 0 got %0d", hangs);
		end
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	task wr(input logic [6:0] a, input logic [7:0] d);
		cpu.access(2'd0, 1'b0, a, 3'd0, d, st);
	endtask : wr
	task rd(input logic ds, input logic [6:0] a, input logic [7:0] e);
		expQ.push_back(e);
		cpu.access(2'd1, ds, a, 3'd0, 8'h00, st);
	endtask : rd
	task prog(input logic [7:0] a, input logic [7:0] d, input logic [1:0] m);
		wr(7'h1E, a);
		wr(7'h1D, d);
		wr(7'h1C, {2'b00, m, 4'b0100});
		wr(7'h1C, {2'b00, m, 4'b0110});
		`CHK("progstall", 2, st)
	endtask : prog
	task fetch(input logic [7:0] a, input logic [7:0] e);
		wr(7'h1E, a);
		cpu.access(2'd2, 1'b0, 7'h1C, 3'd0, 8'h00, st);
		`CHK("readstall", 4, st)
		rd(1'b0, 7'h1D, e);
	endtask : fetch
	initial begin
		void'($urandom(29126));
		repeat (5) @(posedge clock);
		@(negedge clock);
		sys_rst = 0;
		rd(1'b0, 7'h1D, 8'h00);
		wr(7'h1F, 8'hFF);
		rd(1'b0, 7'h1F, 8'h00);
		rd(1'b0, 7'h05, 8'h00);
		cpu.access(2'd0, 1'b1, 7'h3D, 3'd0, 8'h5A, st);
		rd(1'b1, 7'h3D, 8'h5A);
		rd(1'b1, 7'h1D, 8'h00);
		wr(7'h1C, 8'hD8);
		rd(1'b1, 7'h3C, 8'h18);
		cpu.access(2'd3, 1'b0, 7'h1C, 3'd3, 8'h00, st);
		rd(1'b1, 7'h3C, 8'h10);
		cpu.access(2'd2, 1'b1, 7'h3C, 3'd3, 8'h00, st);
		rd(1'b0, 7'h1C, 8'h10);
		$display("test registers done");
		a0 = 8'($urandom);
		d0 = 8'($urandom);
		globalIrqEnable = 1;
		prog(a0, d0, 2'd0);
		wr(7'h1E, ~a0);
		wr(7'h1C, 8'h18);
		cpu.access(2'd2, 1'b0, 7'h1C, 3'd0, 8'h00, st);
		rd(1'b0, 7'h1C, 8'h0A);
		`CHK("irqbusy", 1'b0, readyIrq)
		repeat (AC + 4) @(negedge clock);
		rd(1'b0, 7'h1C, 8'h08);
		`CHK("irqidle", 1'b1, readyIrq)
		globalIrqEnable = 0;
		@(negedge clock);
		`CHK("irqglobal", 1'b0, readyIrq)
		globalIrqEnable = 1;
		rd(1'b0, 7'h1E, a0);
		fetch(a0, d0);
		rd(1'b0, 7'h1C, 8'h08);
		$display("test atomic done");
		ex = 8'hFF;
		for (int i = 0; i < 3; i++) begin
			d0 = 8'($urandom);
			prog(a0, d0, (i == 0) ? 2'd1 : 2'd2);
			repeat (SC + 6) @(negedge clock);
			ex = (i == 0) ? 8'hFF : ex & d0;
			fetch(a0, ex);
		end
		wr(7'h1C, 8'h34);
		wr(7'h1C, 8'h36);
		repeat (6) @(negedge clock);
		rd(1'b0, 7'h1C, 8'h30);
		wr(7'h1C, 8'h02);
		rd(1'b0, 7'h1C, 8'h00);
		wr(7'h1C, 8'h04);
		repeat (6) @(negedge clock);
		wr(7'h1C, 8'h02);
		rd(1'b0, 7'h1C, 8'h00);
		$display("test modes done");
		prog(a0, 8'h00, 2'd1);
		sys_rst = 1;
		repeat (2) @(negedge clock);
		sys_rst = 0;
		rd(1'b0, 7'h1C, 8'h12);
		repeat (SC + 6) @(negedge clock);
		rd(1'b0, 7'h1C, 8'h10);
		fetch(a0, 8'hFF);
		sys_rst = 1;
		@(negedge clock);
		sys_rst = 0;
		rd(1'b0, 7'h1C, 8'h00);
		repeat (3) @(negedge clock);
		$display("test reset done");
		summarize();
	end
endmodule : tb_top
